// file: prom_io_pkg.sv
// Shared constants for the multiplexed-bus ROM and dual port block
package prom_io_pkg;
  localparam int DATA_W       = 8;
  localparam int HI_ADDR_W    = 3;
  localparam int MEM_DEPTH    = 2048;
  localparam int MEM_ADDR_W   = 11;
  localparam int PORT_W       = 8;
  // Low address select codes
  localparam logic [1:0] SEL_FIRST_DATA  = 2'h0;
  localparam logic [1:0] SEL_SECOND_DATA = 2'h1;
  localparam logic [1:0] SEL_FIRST_DIR   = 2'h2;
  localparam logic [1:0] SEL_SECOND_DIR  = 2'h3;
  // Reset values and fixed read values
  localparam logic [7:0] DIR_RESET       = 8'h00;
  localparam logic [7:0] PORT_RESET      = 8'h00;
  localparam logic [7:0] ROM_ERASED      = 8'hFF;
  localparam logic [7:0] DIR_READ_VALUE  = 8'h00;
endpackage

// file: prom_io_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ns
module prom_io_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stage1_q <= reset_val;
      sync_out <= reset_val;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end
endmodule

// file: prom_io_muxed_bus_port.sv
// Multiplexed-bus ROM with two bit-programmable I/O ports
// Summary of operation
// - Latch address, select, enables on strobe fall
// - Memory holds 2048 eight-bit words
// - Upper address affects memory only, not ports
// - Read or write only when both latched enables active
// - Enables inactive: bus and ready released
// - Latched select picks port or memory data
// - Drive bus on read; release when strobes high
// - Port write strobe loads latched target
// - Ready low while enables active, latch high
// - Clock edge releases ready afterwards
// - Two low bits choose first/second port
// - First port read via either strobe form
// - Port read strobe equals select-high read
// - Eight lines each, per-bit direction
// - Reset clears both direction registers
// - Direction zero input, one output
// - Low bits select ports or direction regs
// - Port pins change when write strobe rises
// - Direction registers are write-only
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module prom_io_muxed_bus_port #(
  parameter int MEM_DEPTH = prom_io_pkg::MEM_DEPTH
) (
  // System clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Multiplexed bus
  input  wire logic [7:0] shared_addr_data_lines_in,
  output logic      [7:0] shared_addr_data_lines_out,
  output logic            shared_addr_data_lines_oe,
  input  wire logic [2:0] upper_memory_address,
  input  wire logic       addr_latch_strobe,
  input  wire logic       io_not_mem,
  input  wire logic       enable_active_low_n,
  input  wire logic       enable_active_high,
  input  wire logic       read_strobe_n,
  input  wire logic       port_read_strobe_n,
  input  wire logic       port_write_strobe_n,
  // Ready handshake, pulled low or released
  input  wire logic       bus_clock,
  output logic            ready_out,
  output logic            ready_oe,
  // Device reset pin, active high
  input  wire logic       device_reset,
  // Memory load port for contents
  input  wire logic       rom_load_we,
  input  wire logic [10:0] rom_load_addr,
  input  wire logic [7:0] rom_load_data,
  // First port pins
  input  wire logic [7:0] first_port_lines_in,
  output logic      [7:0] first_port_lines_out,
  output logic      [7:0] first_port_lines_oe,
  // Second port pins
  input  wire logic [7:0] second_port_lines_in,
  output logic      [7:0] second_port_lines_out,
  output logic      [7:0] second_port_lines_oe
);
  localparam int SYNC_W = 8 + 3 + 1 + 1 + 1 + 1 + 1 + 1 + 1 + 1 + 1 + 8 + 8;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise every pin input
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_val;
  logic [SYNC_W-1:0] sync_rst;
  logic [7:0] ad_s;
  logic [2:0] hi_s;
  logic       ale_s;
  logic       iom_s;
  logic       ce1n_s;
  logic       ce2_s;
  logic       rdn_s;
  logic       iorn_s;
  logic       iown_s;
  logic       clk_s;
  logic       rst_s;
  logic [7:0] pa_s;
  logic [7:0] pb_s;

  assign sync_raw = {
    shared_addr_data_lines_in,
    upper_memory_address,
    addr_latch_strobe,
    io_not_mem,
    enable_active_low_n,
    enable_active_high,
    read_strobe_n,
    port_read_strobe_n,
    port_write_strobe_n,
    bus_clock,
    device_reset,
    first_port_lines_in,
    second_port_lines_in
  };
  // Read and write strobes and the active-low enable idle high, latch strobe and active-high enable low, so nothing fires out of reset
  assign sync_rst = {
    8'h00, // Bus
    3'h0,  // Upper address
    1'b0,  // Latch strobe
    1'b0,  // Port or memory select
    1'b1,  // Enable, active low
    1'b0,  // Enable, active high
    1'b1,  // Read strobe
    1'b1,  // Port read strobe
    1'b1,  // Port write strobe
    1'b0,  // Bus clock
    1'b0,  // Device reset
    8'h00, // First port
    8'h00  // Second port
  };
  assign {ad_s, hi_s, ale_s, iom_s, ce1n_s, ce2_s, rdn_s, iorn_s, iown_s, clk_s, rst_s,
          pa_s, pb_s} = sync_val;

  prom_io_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .async_in (sync_raw),
    .reset_val(sync_rst),
    .sync_out (sync_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge history
  logic ale_q;
  logic iown_q;
  logic clk_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ale_q  <= 1'b0;
      iown_q <= 1'b1;
      clk_q  <= 1'b0;
    end else begin
      ale_q  <= ale_s;
      iown_q <= iown_s;
      clk_q  <= clk_s;
    end
  end

  logic ale_fall;
  logic iow_rise;
  logic clk_rise;
  assign ale_fall = ale_q && !ale_s;
  assign iow_rise = !iown_q && iown_s;
  assign clk_rise = !clk_q && clk_s;

  ////////////////////////////////////////////////////////////////////////////
  // Address and enable latch
  logic [7:0] low_addr_q;
  logic [2:0] hi_addr_q;
  logic       iom_q;
  logic       en_q;

  // Both enables asserted: active-low one low, active-high one high
  function automatic logic enables_on(input logic en_low_n, input logic en_high);
    return !en_low_n && en_high;
  endfunction

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      low_addr_q <= 8'h00;
      hi_addr_q  <= 3'h0;
      iom_q      <= 1'b0;
      en_q       <= 1'b0;
    end else if (ale_fall) begin
      low_addr_q <= ad_s;
      hi_addr_q  <= hi_s;
      iom_q      <= iom_s;
      en_q       <= enables_on(ce1n_s, ce2_s);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory array
  logic [7:0]  rom_mem [MEM_DEPTH];
  logic [10:0] rom_index;
  logic [7:0]  rom_q;

  assign rom_index = {hi_addr_q, low_addr_q};

  always_ff @(posedge mclk) begin
    if (rom_load_we) begin
      rom_mem[rom_load_addr] <= rom_load_data;
    end
    // Beyond a shortened array reads as erased
    if (int'(rom_index) < MEM_DEPTH) begin
      rom_q <= rom_mem[rom_index];
    end else begin
      rom_q <= prom_io_pkg::ROM_ERASED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port and direction registers
  logic [7:0] pa_latch_q;
  logic [7:0] pb_latch_q;
  logic [7:0] pa_dir_q;
  logic [7:0] pb_dir_q;
  logic [1:0] sel;
  logic [3:0] target;
  logic       write_act;
  logic       pins_update;

  // One-hot target: first data, second data, first direction, second direction
  function automatic logic [3:0] target_decode(input logic [1:0] code);
    logic [3:0] hot;
    hot = 4'h0;
    unique case (code)
      prom_io_pkg::SEL_FIRST_DATA:  hot = 4'h1;
      prom_io_pkg::SEL_SECOND_DATA: hot = 4'h2;
      prom_io_pkg::SEL_FIRST_DIR:   hot = 4'h4;
      prom_io_pkg::SEL_SECOND_DIR:  hot = 4'h8;
    endcase
    return hot;
  endfunction

  assign sel         = low_addr_q[1:0];
  assign target      = target_decode(sel);
  assign write_act   = en_q && !iown_s;
  // Pins follow the latches only once the write strobe returns high
  assign pins_update = iow_rise || (iown_s && iown_q);

  // Latches follow the bus for as long as the write strobe stays low
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pa_latch_q <= prom_io_pkg::PORT_RESET;
    end else if (write_act && target[0]) begin
      pa_latch_q <= ad_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pb_latch_q <= prom_io_pkg::PORT_RESET;
    end else if (write_act && target[1]) begin
      pb_latch_q <= ad_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || rst_s) begin
      pa_dir_q <= prom_io_pkg::DIR_RESET;
    end else if (write_act && target[2]) begin
      pa_dir_q <= ad_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || rst_s) begin
      pb_dir_q <= prom_io_pkg::DIR_RESET;
    end else if (write_act && target[3]) begin
      pb_dir_q <= ad_s;
    end
  end

  // Each line has its own direction bit and output stage
  for (genvar b = 0; b < prom_io_pkg::PORT_W; b++) begin : g_line
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        first_port_lines_out[b]  <= prom_io_pkg::PORT_RESET[b];
        second_port_lines_out[b] <= prom_io_pkg::PORT_RESET[b];
      end else if (pins_update) begin
        first_port_lines_out[b]  <= pa_latch_q[b];
        second_port_lines_out[b] <= pb_latch_q[b];
      end
    end

    always_ff @(posedge mclk) begin
      if (!resetn) begin
        first_port_lines_oe[b]  <= 1'b0;
        second_port_lines_oe[b] <= 1'b0;
      end else begin
        first_port_lines_oe[b]  <= pa_dir_q[b];
        second_port_lines_oe[b] <= pb_dir_q[b];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic       port_read;
  logic       mem_read;
  logic [7:0] port_data;

  assign port_read = en_q && (!iorn_s || (iom_q && !rdn_s));
  assign mem_read  = en_q && !rdn_s && !iom_q && iorn_s;

  always_comb begin
    port_data = prom_io_pkg::DIR_READ_VALUE;
    if (target[0]) begin
      port_data = pa_s;
    end else if (target[1]) begin
      port_data = pb_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      shared_addr_data_lines_out <= 8'h00;
      shared_addr_data_lines_oe  <= 1'b0;
    end else begin
      shared_addr_data_lines_oe  <= port_read || mem_read;
      shared_addr_data_lines_out <= port_read ? port_data : rom_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready: pulled low during enabled latch strobe, released by clock edge
  logic ready_hold_q;
  logic ready_pull;

  assign ready_pull = ale_s && enables_on(ce1n_s, ce2_s);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ready_hold_q <= 1'b0;
    end else if (ready_pull) begin
      ready_hold_q <= 1'b1;
    end else if (clk_rise || !enables_on(ce1n_s, ce2_s)) begin
      ready_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ready_out <= 1'b0;
      ready_oe  <= 1'b0;
    end else begin
      ready_out <= 1'b0;
      ready_oe  <= ready_hold_q || ready_pull;
    end
  end
endmodule

// file: prom_io_port_sva.sv
// Assertions on the ports of the multiplexed-bus ROM and port block
`timescale 1ns/1ns
module prom_io_port_sva (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       resetn,
  // Bus controls
  input wire logic       addr_latch_strobe,
  input wire logic       enable_active_low_n,
  input wire logic       enable_active_high,
  input wire logic       read_strobe_n,
  input wire logic       port_read_strobe_n,
  input wire logic       port_write_strobe_n,
  input wire logic       bus_clock,
  input wire logic       device_reset,
  // Device outputs
  input wire logic       shared_addr_data_lines_oe,
  input wire logic       ready_out,
  input wire logic       ready_oe,
  input wire logic [7:0] first_port_lines_out,
  input wire logic [7:0] first_port_lines_oe,
  input wire logic [7:0] second_port_lines_out,
  input wire logic [7:0] second_port_lines_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_ready_level: assert property (ready_oe |-> !ready_out)
    else $error("ready driven high");
  a_ready_pull: assert property ((addr_latch_strobe && !enable_active_low_n
    && enable_active_high)[*4] |=> ready_oe) else $error("ready not pulled");
  a_ready_clock: assert property ((!addr_latch_strobe)[*3] ##1 $rose(bus_clock)
    ##1 (!addr_latch_strobe)[*6] |-> !ready_oe) else $error("ready held after clock");
  a_ready_off: assert property ((enable_active_low_n || !enable_active_high)[*4]
    |=> !ready_oe) else $error("ready with enable off");
  a_bus_release: assert property ((read_strobe_n && port_read_strobe_n)[*4]
    |=> !shared_addr_data_lines_oe) else $error("bus not released");
  a_drive_cause: assert property ($rose(shared_addr_data_lines_oe)
    |-> !$past(read_strobe_n, 2) || !$past(port_read_strobe_n, 2)) else $error("drive w/o read");
  a_port_hold: assert property ((!port_write_strobe_n)[*4] |=>
    $stable(first_port_lines_out) && $stable(second_port_lines_out)) else $error("pins moved");
  a_dir_clear: assert property (device_reset[*4] |=>
    first_port_lines_oe == 8'h00 && second_port_lines_oe == 8'h00) else $error("dir kept");
  c_drive: cover property ($rose(shared_addr_data_lines_oe));
  c_ready: cover property ($rose(ready_oe));
  c_write: cover property ($changed(first_port_lines_out));
endmodule

// file: host_cpu_model.sv
// Host processor model driving the multiplexed bus
`timescale 1ns/1ns
module host_cpu_model (
  // Clock
  input  wire logic       mclk,
  // Bus towards the device
  output logic      [7:0] bus_in,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe,
  output logic      [2:0] upper = 3'h0,
  output logic            ale = 1'b0,
  output logic            io_m = 1'b0,
  output logic            en_n = 1'b1,
  output logic            en_h = 1'b0,
  output logic            rd_n = 1'b1,
  output logic            ior_n = 1'b1,
  output logic            iow_n = 1'b1,
  output logic            bclk = 1'b0
);
  logic [7:0] ad_q = 8'h00;
  logic [2:0] div_q = 3'h0;
  // Released bus shows the last host value held in ad_q
  assign bus_in = bus_oe ? bus_out : ad_q;
  always @(posedge mclk) begin
    div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
    if (div_q == 3'h4) bclk <= ~bclk;
  end
  // Kind 0 read, 1 port read strobe, 2 port write
  task automatic access(input logic [1:0] en, input int kind, input logic io,
                        input logic [10:0] a, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk);
    ale   <= 1'b1;
    ad_q  <= a[7:0];
    upper <= a[10:8];
    io_m  <= io;
    en_n  <= ~en[0];
    en_h  <= en[1];
    repeat (5) @(posedge mclk);
    ale <= 1'b0;
    repeat (4) @(posedge mclk);
    ad_q  <= (kind == 2) ? wd : ~a[7:0];
    rd_n  <= (kind != 0);
    ior_n <= (kind != 1);
    iow_n <= (kind != 2);
    repeat (6) @(posedge mclk);
    rd = bus_in;
    rd_n  <= 1'b1;
    ior_n <= 1'b1;
    iow_n <= 1'b1;
    repeat (4) @(posedge mclk);
    ad_q <= ~ad_q;
    repeat (2) @(posedge mclk);
  endtask
endmodule

// file: testbench.sv
// Self-checking bench for the multiplexed-bus ROM and port block
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic        mclk = 1'b0, resetn = 1'b0, device_reset = 1'b0, we = 1'b0;
  logic [10:0] la = 11'h000;
  logic [7:0]  ld = 8'h00, bin, bout, pao, paoe, pbo, pboe, rd;
  logic [2:0]  up;
  logic        boe, ale, iom, en_n, en_h, rd_n, ior_n, iow_n, bclk, rdy, rdy_oe;
  logic [10:0] ma [4] = '{11'h000, 11'h7FF, 11'h0C1, 11'h4C1};
  logic [7:0]  md [4] = '{8'h3C, 8'hA5, 8'h96, 8'h5A};
  int          errors = 0, compares = 0, cycles = 0;
  int          rdy_cyc = 0, rdy_base = 0;
  logic [7:0]  pai = 8'hC3, pbi = 8'h3C;
  always #10 mclk = ~mclk;
  // Cycles in which ready is pulled low
  always @(posedge mclk) if (rdy_oe) rdy_cyc <= rdy_cyc + 1;
  prom_io_muxed_bus_port prom_io_muxed_bus_port_i (.mclk(mclk), .resetn(resetn),
    .shared_addr_data_lines_in(bin), .shared_addr_data_lines_out(bout),
    .shared_addr_data_lines_oe(boe), .upper_memory_address(up), .addr_latch_strobe(ale),
    .io_not_mem(iom), .enable_active_low_n(en_n), .enable_active_high(en_h),
    .read_strobe_n(rd_n), .port_read_strobe_n(ior_n), .port_write_strobe_n(iow_n),
    .bus_clock(bclk), .ready_out(rdy), .ready_oe(rdy_oe), .device_reset(device_reset),
    .rom_load_we(we), .rom_load_addr(la), .rom_load_data(ld),
    .first_port_lines_in(pai), .first_port_lines_out(pao), .first_port_lines_oe(paoe),
    .second_port_lines_in(pbi), .second_port_lines_out(pbo), .second_port_lines_oe(pboe));
  host_cpu_model host_cpu_model_i (.mclk(mclk), .bus_in(bin), .bus_out(bout), .bus_oe(boe),
    .upper(up), .ale(ale), .io_m(iom), .en_n(en_n), .en_h(en_h), .rd_n(rd_n),
    .ior_n(ior_n), .iow_n(iow_n), .bclk(bclk));
  task automatic tally_and_finish();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      we <= 1'b1;
      la <= ma[i];
      ld <= md[i];
      @(posedge mclk);
    end
    we <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      host_cpu_model_i.access(2'b11, 0, 1'b0, ma[i], 8'h00, rd);
      `CHK(rd, md[i])
    end
    `CHK(rdy_cyc != 0, 1'b1)
    `CHK(rdy, 1'b0)
    `CHK(rdy_oe, 1'b0)
    `CHK(boe, 1'b0)
    $display("test memory done");
    host_cpu_model_i.access(2'b11, 2, 1'b1, 11'h502, 8'hF0, rd);
    host_cpu_model_i.access(2'b11, 2, 1'b0, 11'h0FF, 8'h0F, rd);
    `CHK(paoe, 8'hF0)
    `CHK(pboe, 8'h0F)
    host_cpu_model_i.access(2'b11, 2, 1'b1, 11'h700, 8'h81, rd);
    host_cpu_model_i.access(2'b11, 2, 1'b0, 11'h001, 8'h42, rd);
    `CHK(pao, 8'h81)
    `CHK(pbo, 8'h42)
    host_cpu_model_i.access(2'b11, 0, 1'b1, 11'h600, 8'h00, rd);
    `CHK(rd, 8'hC3)
    pai <= 8'h5A;
    host_cpu_model_i.access(2'b11, 1, 1'b0, 11'h004, 8'h00, rd);
    `CHK(rd, 8'h5A)
    host_cpu_model_i.access(2'b11, 1, 1'b1, 11'h201, 8'h00, rd);
    `CHK(rd, 8'h3C)
    host_cpu_model_i.access(2'b11, 0, 1'b1, 11'h002, 8'h00, rd);
    `CHK(rd, prom_io_pkg::DIR_READ_VALUE)
    $display("test ports done");
    rdy_base = rdy_cyc;
    for (int i = 1; i < 3; i++) begin
      host_cpu_model_i.access(i[1:0], 2, 1'b1, 11'h000, 8'h55, rd);
      `CHK(pao, 8'h81)
      host_cpu_model_i.access(i[1:0], 0, 1'b0, 11'h0C1, 8'h00, rd);
      `CHK(rd, 8'h3E)
    end
    `CHK(rdy_cyc, rdy_base)
    $display("test disabled done");
    device_reset <= 1'b1;
    repeat (5) @(posedge mclk);
    device_reset <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(paoe, prom_io_pkg::DIR_RESET)
    `CHK(pboe, prom_io_pkg::DIR_RESET)
    $display("test reset done");
    tally_and_finish();
  end
endmodule
bind prom_io_muxed_bus_port prom_io_port_sva prom_io_port_sva_i (.mclk(mclk),
  .resetn(resetn), .addr_latch_strobe(addr_latch_strobe),
  .enable_active_low_n(enable_active_low_n), .enable_active_high(enable_active_high),
  .read_strobe_n(read_strobe_n), .port_read_strobe_n(port_read_strobe_n),
  .port_write_strobe_n(port_write_strobe_n), .bus_clock(bus_clock),
  .device_reset(device_reset), .shared_addr_data_lines_oe(shared_addr_data_lines_oe),
  .ready_out(ready_out), .ready_oe(ready_oe), .first_port_lines_out(first_port_lines_out),
  .first_port_lines_oe(first_port_lines_oe), .second_port_lines_out(second_port_lines_out),
  .second_port_lines_oe(second_port_lines_oe));
